// File: logic/tpc_pin_function.sv
// Purpose: Pin function control for a three channel pulse timer unit.
// Assumes: Counter logic on ref_clk supplies counts, match and clear pulses.
// Notes:   Pins pass two flip-flops before edge detection.
`timescale 1ns/1ps
module tpc_pin_function #(
   parameter int CNT_W = 16                 // Counter width.
) (
   input  wire logic             ref_clk,        // 25 MHz clock.
   input  wire logic             rst_n,          // Async reset, low.
   input  wire logic             hsel,           // Slave select.
   input  wire logic [7:0]       haddr,          // Byte address.
   input  wire logic [1:0]       htrans,         // Transfer type.
   input  wire logic             hwrite,         // Write access.
   input  wire logic [2:0]       hsize,          // Transfer size.
   input  wire logic [31:0]      hwdata,         // Write data.
   input  wire logic             hready,         // Bus ready.
   output logic                  hreadyout,      // Always ready.
   output logic                  hresp,          // Always OKAY.
   output logic [31:0]           hrdata,         // Read data.
   input  wire logic [CNT_W-1:0] cntCh0,         // Channel 0 count.
   input  wire logic [CNT_W-1:0] cntCh1,         // Channel 1 count.
   input  wire logic [CNT_W-1:0] cntCh2,         // Channel 2 count.
   input  wire logic [7:0]       compareMatch,   // Match pulse per reg.
   input  wire logic [2:0]       counterClear,   // Clear pulse per ch.
   input  wire logic [7:0]       pinIn,          // Capture pins.
   output logic [7:0]            pinOut,         // Compare pin level.
   output logic [7:0]            pinOe,          // Pin drive enable.
   output logic [2:0]            runBit,         // Counter run bits.
   output logic                  bufA,           // Pair A/C buffered.
   output logic                  bufB,           // Pair B/D buffered.
   output logic [7:0]            captureDone,    // Capture happened.
   output logic                  irq             // Interrupt level.
);
   // ------------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------------
   logic [7:0]       ctrlCh0High;
   logic [7:0]       ctrlCh0Low;
   logic [7:0]       ctrlCh1;
   logic [7:0]       ctrlCh2;
   logic [3:0]       mode [3];
   logic [15:0]      status;
   logic [15:0]      irqEnable;
   logic [CNT_W-1:0] capVal [tpc_pkg::NUM_GEN];
   logic [CNT_W-1:0] cnt [3];
   logic [3:0]       fld [tpc_pkg::NUM_GEN];
   logic [7:0]       sync1;
   logic [7:0]       sync2;
   logic [7:0]       pinPrev;
   logic [7:0]       capEv;
   logic [7:0]       matchEv;
   logic [7:0]       inhibit;
   logic             wrPend;
   logic [7:0]       wrAddr;
   logic             rdPend;
   logic [7:0]       rdAddr;
   logic             wrStb;

   // Channel that owns a general register index.
   function automatic int chOf(input int idx);
      chOf = (idx < 4) ? 0 : ((idx < 6) ? 1 : 2);
   endfunction

   // True when a field asks for a capture the hardware refuses.
   function automatic logic badCapture(input logic [3:0] f, input int idx);
      badCapture = f[tpc_pkg::FLD_CAPTURE] && f[tpc_pkg::FLD_INIT] && (chOf(idx) < 2);
   endfunction

   assign cnt[0] = cntCh0;
   assign cnt[1] = cntCh1;
   assign cnt[2] = cntCh2;

   // Field split: upper nibble serves B or D, lower nibble A or C.
   assign fld[0] = ctrlCh0High[tpc_pkg::FLD_LO_LSB +: 4];
   assign fld[1] = ctrlCh0High[tpc_pkg::FLD_HI_LSB +: 4];
   assign fld[2] = ctrlCh0Low[tpc_pkg::FLD_LO_LSB +: 4];
   assign fld[3] = ctrlCh0Low[tpc_pkg::FLD_HI_LSB +: 4];
   assign fld[4] = ctrlCh1[tpc_pkg::FLD_LO_LSB +: 4];
   assign fld[5] = ctrlCh1[tpc_pkg::FLD_HI_LSB +: 4];
   assign fld[6] = ctrlCh2[tpc_pkg::FLD_LO_LSB +: 4];
   assign fld[7] = ctrlCh2[tpc_pkg::FLD_HI_LSB +: 4];

   // A buffer register loses its compare and capture duty entirely.
   always_comb
   begin
      inhibit = 8'h00;
      inhibit[tpc_pkg::IDX_CH0_C] = bufA;
      inhibit[tpc_pkg::IDX_CH0_D] = bufB;
   end

   // ------------------------------------------------------------------
   // AHB-Lite slave
   // ------------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign wrStb     = wrPend;

   // Address phase is latched; the data phase then reads or writes.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wrPend <= 1'b0;
         rdPend <= 1'b0;
         wrAddr <= 8'h00;
         rdAddr <= 8'h00;
      end
      else if (hready)
      begin
         wrPend <= hsel && htrans == tpc_pkg::HTRANS_NSEQ && hwrite;
         rdPend <= hsel && htrans == tpc_pkg::HTRANS_NSEQ && !hwrite;
         wrAddr <= haddr;
         rdAddr <= haddr;
      end
   end

   // Control registers; byte-wide, reset to zero.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrlCh0High <= tpc_pkg::CTRL_RESET;
         ctrlCh0Low  <= tpc_pkg::CTRL_RESET;
         ctrlCh1     <= tpc_pkg::CTRL_RESET;
         ctrlCh2     <= tpc_pkg::CTRL_RESET;
      end
      else if (wrStb)
      begin
         case (wrAddr)
            tpc_pkg::OFS_CH0_HIGH: ctrlCh0High <= hwdata[7:0];
            tpc_pkg::OFS_CH0_LOW:  ctrlCh0Low  <= hwdata[7:0];
            tpc_pkg::OFS_CH1:      ctrlCh1     <= hwdata[7:0];
            tpc_pkg::OFS_CH2:      ctrlCh2     <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // Mode, buffer and run bits.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode[0] <= tpc_pkg::MODE_RESET;
         mode[1] <= tpc_pkg::MODE_RESET;
         mode[2] <= tpc_pkg::MODE_RESET;
         bufA    <= 1'b0;
         bufB    <= 1'b0;
         runBit  <= 3'h0;
      end
      else if (wrStb)
      begin
         case (wrAddr)
            tpc_pkg::OFS_MODE0:
            begin
               mode[0] <= hwdata[3:0];
               bufA    <= hwdata[tpc_pkg::BUF_A_BIT];
               bufB    <= hwdata[tpc_pkg::BUF_B_BIT];
            end
            tpc_pkg::OFS_MODE1: mode[1] <= hwdata[3:0];
            tpc_pkg::OFS_MODE2: mode[2] <= hwdata[3:0];
            tpc_pkg::OFS_START: runBit  <= hwdata[2:0];
            default: ;
         endcase
      end
   end

   // Interrupt enable register.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         irqEnable <= 16'h0000;
      else if (wrStb && wrAddr == tpc_pkg::OFS_ENABLE)
         irqEnable <= hwdata[15:0];
   end

   // Sticky status; a new event beats a clear in the same cycle.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         status <= 16'h0000;
      else if (wrStb && wrAddr == tpc_pkg::OFS_CLEAR)
         status <= (status & ~hwdata[15:0]) | {matchEv, capEv};
      else
         status <= status | {matchEv, capEv};
   end

   assign irq = |(status & irqEnable);

   // Read mux in the data phase; registers are read as they stand now,
   // so a read right after a write already sees the new value.
   always_comb
   begin
      hrdata = 32'h0000_0000;
      if (rdPend)
      begin
         case (rdAddr)
            tpc_pkg::OFS_CH0_HIGH: hrdata[7:0] = ctrlCh0High;
            tpc_pkg::OFS_CH0_LOW:  hrdata[7:0] = ctrlCh0Low;
            tpc_pkg::OFS_CH1:      hrdata[7:0] = ctrlCh1;
            tpc_pkg::OFS_CH2:      hrdata[7:0] = ctrlCh2;
            tpc_pkg::OFS_MODE0:    hrdata[7:0] = {tpc_pkg::MODE_FIXED, bufB, bufA, mode[0]};
            tpc_pkg::OFS_MODE1:    hrdata[7:0] = {tpc_pkg::MODE_FIXED, 2'h0, mode[1]};
            tpc_pkg::OFS_MODE2:    hrdata[7:0] = {tpc_pkg::MODE_FIXED, 2'h0, mode[2]};
            tpc_pkg::OFS_START:    hrdata[2:0] = runBit;
            tpc_pkg::OFS_STATUS:   hrdata[15:0] = status;
            tpc_pkg::OFS_ENABLE:   hrdata[15:0] = irqEnable;
            default:
            begin
               if (rdAddr[7:5] == tpc_pkg::OFS_CAPTURE[7:5] && rdAddr[1:0] == 2'h0)
                  hrdata[CNT_W-1:0] = capVal[rdAddr[4:2]];
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Capture path
   // ------------------------------------------------------------------
   // Two-stage synchroniser; only the second stage feeds edge logic.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1   <= 8'h00;
         sync2   <= 8'h00;
         pinPrev <= 8'h00;
      end
      else
      begin
         sync1   <= pinIn;
         sync2   <= sync1;
         pinPrev <= sync2;
      end
   end

   // Qualified edges and compare events per general register.
   always_comb
   begin
      capEv   = 8'h00;
      matchEv = 8'h00;
      for (int i = 0; i < tpc_pkg::NUM_GEN; i++)
      begin
         if (fld[i][tpc_pkg::FLD_CAPTURE] && !inhibit[i] && !badCapture(fld[i], i))
         begin
            if (fld[i][1])
               capEv[i] = sync2[i] ^ pinPrev[i];
            else if (fld[i][1:0] == tpc_pkg::EDGE_FALL)
               capEv[i] = !sync2[i] && pinPrev[i];
            else
               capEv[i] = sync2[i] && !pinPrev[i];
         end
         if (!fld[i][tpc_pkg::FLD_CAPTURE] && !inhibit[i] && runBit[chOf(i)])
            matchEv[i] = compareMatch[i];
      end
   end

   // Counter value is latched in the very cycle the edge is seen.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < tpc_pkg::NUM_GEN; i++)
            capVal[i] <= '0;
         captureDone <= 8'h00;
      end
      else
      begin
         for (int i = 0; i < tpc_pkg::NUM_GEN; i++)
            if (capEv[i])
               capVal[i] <= cnt[chOf(i)];
         captureDone <= capEv;
      end
   end

   // ------------------------------------------------------------------
   // Compare pin path
   // ------------------------------------------------------------------
   // Halted counter forces the initial level; a match beats a PWM
   // mode 2 clear so that a zero-width pulse still shows its edge.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         pinOut <= 8'h00;
      else
      begin
         for (int i = 0; i < tpc_pkg::NUM_GEN; i++)
         begin
            if (!runBit[chOf(i)])
               pinOut[i] <= fld[i][tpc_pkg::FLD_INIT];
            else if (matchEv[i])
            begin
               case (fld[i][1:0])
                  tpc_pkg::ACT_LOW:    pinOut[i] <= 1'b0;
                  tpc_pkg::ACT_HIGH:   pinOut[i] <= 1'b1;
                  tpc_pkg::ACT_TOGGLE: pinOut[i] <= !pinOut[i];
                  default:             pinOut[i] <= pinOut[i];
               endcase
            end
            else if (mode[chOf(i)] == tpc_pkg::MODE_PWM2 && counterClear[chOf(i)])
               pinOut[i] <= fld[i][tpc_pkg::FLD_INIT];
         end
      end
   end

   // Drive only when the field is compare with an active code.
   always_comb
   begin
      for (int i = 0; i < tpc_pkg::NUM_GEN; i++)
         pinOe[i] = !fld[i][tpc_pkg::FLD_CAPTURE] && fld[i][1:0] != tpc_pkg::ACT_OFF && !inhibit[i];
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   a_ctrl_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $changed(ctrlCh2) |-> $past(wrStb) && $past(wrAddr) == tpc_pkg::OFS_CH2)
      else $error("ch2 control changed without a write");
   a_d_silent: assert property (@(posedge ref_clk) disable iff (!rst_n)
      bufB |-> !capEv[3] && !matchEv[3] && !pinOe[3])
      else $error("buffered D register still active");
   a_bad_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
      fld[0][3:2] == 2'h3 |-> !capEv[0])
      else $error("prohibited capture code captured");
   a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
      irq == |(status & irqEnable))
      else $error("interrupt level wrong");

   for (genvar g = 0; g < 8; g++)
   begin : g_chk
      a_match_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
         matchEv[g] && fld[g][1:0] == tpc_pkg::ACT_LOW && runBit[chOf(g)] |=> !pinOut[g])
         else $error("low on match failed");
      a_match_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
         matchEv[g] && fld[g][1:0] == tpc_pkg::ACT_HIGH && runBit[chOf(g)] |=> pinOut[g])
         else $error("high on match failed");
      a_match_toggle: assert property (@(posedge ref_clk) disable iff (!rst_n)
         matchEv[g] && fld[g][1:0] == tpc_pkg::ACT_TOGGLE && runBit[chOf(g)] |=> pinOut[g] != $past(pinOut[g]))
         else $error("toggle on match failed");
      a_halt_init: assert property (@(posedge ref_clk) disable iff (!rst_n)
         !runBit[chOf(g)] |=> pinOut[g] == $past(fld[g][2]))
         else $error("halted pin not at initial level");
      a_pwm2_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
         runBit[chOf(g)] && !matchEv[g] && counterClear[chOf(g)] && mode[chOf(g)] == tpc_pkg::MODE_PWM2
         |=> pinOut[g] == $past(fld[g][2]))
         else $error("pwm2 clear level wrong");
      a_cap_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
         fld[g][3] && fld[g][1:0] == tpc_pkg::EDGE_RISE && !inhibit[g] && !badCapture(fld[g], g)
         && sync2[g] && !pinPrev[g] |=> capVal[g] == $past(cnt[chOf(g)]) && captureDone[g])
         else $error("rising capture missed");
      a_cap_fall: assert property (@(posedge ref_clk) disable iff (!rst_n)
         fld[g][3] && fld[g][1:0] == tpc_pkg::EDGE_FALL && !inhibit[g] && !badCapture(fld[g], g)
         && !sync2[g] && pinPrev[g] |=> captureDone[g] ##1 status[g])
         else $error("falling capture missed");
      a_cap_both: assert property (@(posedge ref_clk) disable iff (!rst_n)
         fld[g][3] && fld[g][1] && !inhibit[g] && !badCapture(fld[g], g)
         && $changed(sync2[g]) |-> capEv[g])
         else $error("both-edge capture missed");
   end

   c_toggle: cover property (@(posedge ref_clk) disable iff (!rst_n)
      matchEv[1] && fld[1][1:0] == tpc_pkg::ACT_TOGGLE);
   c_capture: cover property (@(posedge ref_clk) disable iff (!rst_n) capEv[0] ##1 irq);
   c_buffered: cover property (@(posedge ref_clk) disable iff (!rst_n) bufA && compareMatch[2]);
endmodule

// File: include/tpc_pkg.sv
// Purpose: Shared constants for the timer pin function control block.
// Assumes: AHB-Lite word registers, eight general match/capture registers.
// Notes:   Register index order is ch0 A,B,C,D, ch1 A,B, ch2 A,B.
package tpc_pkg;
   // -----------------------------------------------------------------
   // Register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CH0_HIGH = 8'h00;
   localparam logic [7:0] OFS_CH0_LOW  = 8'h04;
   localparam logic [7:0] OFS_CH1      = 8'h08;
   localparam logic [7:0] OFS_CH2      = 8'h0c;
   localparam logic [7:0] OFS_MODE0    = 8'h10;
   localparam logic [7:0] OFS_MODE1    = 8'h14;
   localparam logic [7:0] OFS_MODE2    = 8'h18;
   localparam logic [7:0] OFS_START    = 8'h1c;
   localparam logic [7:0] OFS_STATUS   = 8'h20;
   localparam logic [7:0] OFS_CLEAR    = 8'h24;
   localparam logic [7:0] OFS_ENABLE   = 8'h28;
   localparam logic [7:0] OFS_CAPTURE  = 8'h40;
   // -----------------------------------------------------------------
   // Reset values and field layout
   // -----------------------------------------------------------------
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [3:0] MODE_RESET   = 4'h0;
   localparam logic [1:0] MODE_FIXED   = 2'h3;
   localparam int         FLD_HI_LSB   = 4;
   localparam int         FLD_LO_LSB   = 0;
   localparam int         FLD_CAPTURE  = 3;
   localparam int         FLD_INIT     = 2;
   localparam int         BUF_A_BIT    = 4;
   localparam int         BUF_B_BIT    = 5;
   localparam int         NUM_GEN      = 8;
   localparam int         IDX_CH0_C    = 2;
   localparam int         IDX_CH0_D    = 3;
   // -----------------------------------------------------------------
   // Encodings
   // -----------------------------------------------------------------
   localparam logic [1:0] ACT_OFF      = 2'h0;
   localparam logic [1:0] ACT_LOW      = 2'h1;
   localparam logic [1:0] ACT_HIGH     = 2'h2;
   localparam logic [1:0] ACT_TOGGLE   = 2'h3;
   localparam logic [1:0] EDGE_RISE    = 2'h0;
   localparam logic [1:0] EDGE_FALL    = 2'h1;
   localparam logic [3:0] MODE_PWM2    = 4'h3;
   localparam logic [1:0] HTRANS_NSEQ  = 2'h2;
endpackage

// File: tb/tpc_pin_model.sv
// Purpose: Far side model of the timer capture and compare pins.
// Assumes: A pin that the block drives shows the block's level.
// Notes:   Undriven pins show the level last set by the bench.
`timescale 1ns/1ps
module tpc_pin_model (
   input  wire logic [7:0] pinOut,   // Block pin levels.
   input  wire logic [7:0] pinOe,    // Block drive enables.
   output logic      [7:0] pinIn     // Resolved pin wires.
);
   logic [7:0] extLvl;               // Level forced by the far side.
   // Resolve each wire; the block wins wherever it drives, so a compare pin never feeds stale levels back.
   assign pinIn = (pinOe & pinOut) | (~pinOe & extLvl);
   initial extLvl = 8'h00;
   // Move one pin; callers sit just after a rising edge.
   task automatic drive(input int i, input logic v);
      extLvl[i] <= v;
   endtask
endmodule

// File: tb/tpc_pin_function_tb_top.sv
// Purpose: Self-checking bench for the timer pin function control block.
// Assumes: Zero wait bus slave; counts held constant so captures are known.
// Notes:   Capture pins pass a synchroniser, so waits after pin moves are generous.
`timescale 1ns/1ps
module tpc_pin_function_tb_top;
   logic        ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, bufA, bufB, irq;
   logic [7:0]  haddr, compareMatch, pinIn, pinOut, pinOe, captureDone;
   logic [1:0]  htrans;
   logic [2:0]  hsize, counterClear, runBit;
   logic [31:0] hwdata, hrdata;
   logic [15:0] cnt [3] = '{16'h0a0a, 16'h1234, 16'h2b2b};
   int          miscompares, nCompared;
   int          capPulses;
   logic [7:0]  ctrlOfs [4] = '{tpc_pkg::OFS_CH0_HIGH, tpc_pkg::OFS_CH0_LOW, tpc_pkg::OFS_CH1, tpc_pkg::OFS_CH2};
   logic [7:0]  capOfs [5] = '{tpc_pkg::OFS_CH1, tpc_pkg::OFS_CH1, tpc_pkg::OFS_CH1,
                               tpc_pkg::OFS_CH0_HIGH, tpc_pkg::OFS_CH2};
   logic [31:0] capVal [5] = '{32'h08, 32'h09, 32'ha0, 32'h0c, 32'h0c};
   int          capIdx [5] = '{4, 4, 5, 0, 6};
   logic        capRise [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
   logic        capFall [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

   tpc_pin_function dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cntCh0(cnt[0]),
      .cntCh1(cnt[1]), .cntCh2(cnt[2]), .compareMatch(compareMatch),
      .counterClear(counterClear), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
      .runBit(runBit), .bufA(bufA), .bufB(bufB), .captureDone(captureDone), .irq(irq));
   tpc_pin_model pins (.pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));

   // 25 MHz clock.
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // Report counts, give the verdict and end the run.
   task automatic stop_test;
      $display("Compared %0d, mismatches %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Compare one result with case equality so unknowns never match.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      nCompared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // One single AHB-Lite transfer; read data is taken at the data phase's ready edge.
   task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= tpc_pkg::HTRANS_NSEQ;
      hwrite <= wr;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1)
         @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1)
         @(posedge ref_clk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      bus(a, 1'b1, d, v);
      // The register only updates at the edge ending the data phase, so wait one edge before outputs are looked at.
      @(posedge ref_clk);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] v;
      bus(a, 1'b0, 32'h0, v);
      chk(what, exp, v);
   endtask

   // Pulse a match for one cycle and look at the pin in the very next cycle.
   task automatic hit(input int i, input logic exp);
      compareMatch <= 8'h01 << i;
      @(posedge ref_clk);
      compareMatch <= 8'h00;
      @(posedge ref_clk);
      chk("pin after match", {31'h0, exp}, {31'h0, pinOut[i]});
   endtask

   // Count capture pulses out of reset; each qualified pin edge gives exactly one.
   always @(posedge ref_clk)
   begin
      if (rst_n)
         capPulses <= capPulses + $countones(captureDone);
   end

   task automatic pinChk(input string what, input int i, input logic exp);
      tick(2);
      chk(what, {31'h0, exp}, {31'h0, pinOut[i]});
   endtask

   // Give up on a hang; the whole sequence needs well under 3000 cycles.
   initial
   begin
      tick(6000);
      miscompares++;
      stop_test();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      compareMatch = 8'h00;
      counterClear = 3'h0;
      tick(16);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      // Reset values, full width access and the four control registers.
      foreach (ctrlOfs[i])
      begin
         rdc(ctrlOfs[i], 32'h0, "ctrl reset");
         wr(ctrlOfs[i], 32'hffff_ff3c);
         rdc(ctrlOfs[i], 32'h3c, "ctrl pattern");
         wr(ctrlOfs[i], 32'hc3);
         rdc(ctrlOfs[i], 32'hc3, "ctrl pattern");
         wr(ctrlOfs[i], 32'h0);
      end
      rdc(tpc_pkg::OFS_MODE0, 32'hc0, "mode reset");
      rdc(8'h3c, 32'h0, "unmapped");
      // Compare actions on register B of channel 0, with its interrupt.
      wr(tpc_pkg::OFS_CLEAR, 32'hffff);
      wr(tpc_pkg::OFS_ENABLE, 32'h200);
      wr(tpc_pkg::OFS_CH0_HIGH, 32'h20);
      pinChk("halted low", 1, 1'b0);
      wr(tpc_pkg::OFS_START, 32'h1);
      chk("run bits", 32'h1, {29'h0, runBit});
      hit(1, 1'b1);
      chk("irq set", 32'h1, {31'h0, irq});
      wr(tpc_pkg::OFS_CH0_HIGH, 32'h30);
      hit(1, 1'b0);
      hit(1, 1'b1);
      wr(tpc_pkg::OFS_CH0_HIGH, 32'h10);
      hit(1, 1'b0);
      chk("drive on", 32'h1, {31'h0, pinOe[1]});
      wr(tpc_pkg::OFS_CH0_HIGH, 32'h0);
      chk("drive off", 32'h0, {31'h0, pinOe[1]});
      rdc(tpc_pkg::OFS_STATUS, 32'h200, "status");
      wr(tpc_pkg::OFS_ENABLE, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(tpc_pkg::OFS_ENABLE, 32'h200);
      wr(tpc_pkg::OFS_CLEAR, 32'h200);
      chk("irq cleared", 32'h0, {31'h0, irq});
      wr(tpc_pkg::OFS_START, 32'h0);
      wr(tpc_pkg::OFS_CH0_HIGH, 32'h50);
      pinChk("halted high", 1, 1'b1);
      // Second PWM mode reloads the initial level at counter clear.
      wr(tpc_pkg::OFS_MODE0, {24'h0, 6'h0, tpc_pkg::MODE_PWM2[1:0]});
      wr(tpc_pkg::OFS_START, 32'h1);
      hit(1, 1'b0);
      counterClear <= 3'h1;
      @(posedge ref_clk);
      counterClear <= 3'h0;
      pinChk("clear level", 1, 1'b1);
      // Buffer pairs: D silenced by the B pair bit, C by the A pair bit.
      wr(tpc_pkg::OFS_MODE0, 32'h20);
      rdc(tpc_pkg::OFS_MODE0, 32'he0, "mode bufB");
      chk("bufB", 32'h1, {31'h0, bufB});
      wr(tpc_pkg::OFS_CH0_HIGH, 32'h0);
      wr(tpc_pkg::OFS_CH0_LOW, 32'h22);
      wr(tpc_pkg::OFS_CLEAR, 32'hffff);
      hit(3, 1'b0);
      hit(2, 1'b1);
      chk("D undriven", 32'h0, {31'h0, pinOe[3]});
      wr(tpc_pkg::OFS_CH0_LOW, 32'h80);
      pins.drive(3, 1'b1);
      tick(8);
      rdc(tpc_pkg::OFS_STATUS, 32'h400, "buffered D");
      wr(tpc_pkg::OFS_MODE0, 32'h30);
      chk("bufA", 32'h1, {31'h0, bufA});
      wr(tpc_pkg::OFS_CH0_LOW, 32'h03);
      wr(tpc_pkg::OFS_CLEAR, 32'hffff);
      compareMatch <= 8'h04;
      @(posedge ref_clk);
      compareMatch <= 8'h00;
      tick(2);
      rdc(tpc_pkg::OFS_STATUS, 32'h0, "buffered C");
      chk("C undriven", 32'h0, {31'h0, pinOe[2]});
      pins.drive(3, 1'b0);
      wr(tpc_pkg::OFS_MODE0, 32'h0);
      wr(tpc_pkg::OFS_CH0_LOW, 32'h0);
      tick(8);
      // Capture edge codes, both-edge code and the prohibited channel 0 code.
      for (int k = 0; k < 5; k++)
      begin
         wr(capOfs[k], capVal[k]);
         wr(tpc_pkg::OFS_CLEAR, 32'hffff);
         pins.drive(capIdx[k], 1'b1);
         tick(8);
         rdc(tpc_pkg::OFS_STATUS, 32'(capRise[k]) << capIdx[k], "rise status");
         wr(tpc_pkg::OFS_CLEAR, 32'hffff);
         pins.drive(capIdx[k], 1'b0);
         tick(8);
         rdc(tpc_pkg::OFS_STATUS, 32'(capFall[k]) << capIdx[k], "fall status");
         rdc(tpc_pkg::OFS_CAPTURE + 8'(4 * capIdx[k]),
             (capRise[k] | capFall[k]) ? {16'h0, cnt[capIdx[k] < 4 ? 0 : (capIdx[k] < 6 ? 1 : 2)]} : 32'h0,
             "capture value");
         wr(capOfs[k], 32'h0);
      end
      // Five qualified edges in the capture loop: rise, fall, two for both edges, one on channel 2.
      chk("capture pulses", 32'h5, 32'(capPulses));
      stop_test();
   end
endmodule
